// ==== src/tbs_serializer_map.vh ====
// Constants for the ten-bit serializer front end: register map, field positions,
// reset values, frame and sync counts, test access port states and instructions.
// Included by the serializer module; holds definitions only.
`ifndef TBS_SERIALIZER_MAP_VH
`define TBS_SERIALIZER_MAP_VH

// Register offsets on the plain register port.
`define TBS_ADDR_W 4
`define TBS_OFS_CTRL 4'h0
`define TBS_OFS_STATUS 4'h4
`define TBS_OFS_SYNC_CNT 4'h8
`define TBS_OFS_WORD_CNT 4'hc

// Control register fields.
`define TBS_CTRL_MSB_FIRST 0
`define TBS_CTRL_RESET 1'h0

// Status register fields.
`define TBS_STAT_SYNC_ACTIVE 0
`define TBS_STAT_ASLEEP 1
`define TBS_STAT_DRIVING 2
`define TBS_STAT_OVERFLOW 3
`define TBS_STAT_FIFO_EMPTY 4

// Frame layout and sync burst.
`define TBS_DATA_W 10
`define TBS_FRAME_BITS 12
`define TBS_BIT_CNT_W 4
`define TBS_LAST_BIT 4'hb
`define TBS_CLK_BIT_START 1'h1
`define TBS_CLK_BIT_END 1'h0
`define TBS_SYNC_MIN 11'h400
`define TBS_SYNC_CNT_W 11
`define TBS_SYNC_SYMBOL 10'h01f
`define TBS_FIFO_DEPTH 4

// Test access port states.
`define TBS_TAP_RESET 4'h0
`define TBS_TAP_IDLE 4'h1
`define TBS_TAP_SEL_DR 4'h2
`define TBS_TAP_CAP_DR 4'h3
`define TBS_TAP_SHIFT_DR 4'h4
`define TBS_TAP_EXIT1_DR 4'h5
`define TBS_TAP_PAUSE_DR 4'h6
`define TBS_TAP_EXIT2_DR 4'h7
`define TBS_TAP_UPD_DR 4'h8
`define TBS_TAP_SEL_IR 4'h9
`define TBS_TAP_CAP_IR 4'ha
`define TBS_TAP_SHIFT_IR 4'hb
`define TBS_TAP_EXIT1_IR 4'hc
`define TBS_TAP_PAUSE_IR 4'hd
`define TBS_TAP_EXIT2_IR 4'he
`define TBS_TAP_UPD_IR 4'hf

// Test instructions and the fixed capture value of the instruction register.
`define TBS_IR_SAMPLE 2'h1
`define TBS_IR_IDCODE 2'h2
`define TBS_IR_BYPASS 2'h3
`define TBS_IR_CAPTURE 2'h1
`define TBS_BSR_LEN 16

`endif

// ==== src/tbs_fifo.v ====
// Small first-in first-out buffer built as a shifting register file.
// Assumes one clock, an active-low asynchronous reset and a clock enable.
`timescale 1ns/1ps
module tbs_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 4,
	parameter CNT_W = 3
) (
	// Clock and reset
	input wire i_clock,
	input wire i_reset_n,
	input wire i_clock_en,
	input wire i_flush,
	// Filling side
	input wire i_in_valid,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_in_ready,
	// Draining side
	output wire o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input wire i_out_ready
);
	reg [WIDTH-1:0] entry_q [0:DEPTH-1];
	reg [CNT_W-1:0] count_q;
	wire push;
	wire pop;
	genvar i;

	assign o_in_ready = (count_q != DEPTH[CNT_W-1:0]);
	assign o_out_valid = (count_q != {CNT_W{1'b0}});
	// The head always sits in entry zero, so the read data come from a register.
	assign o_out_data = entry_q[0];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_q <= {CNT_W{1'b0}};
		end else if (i_clock_en) begin
			if (i_flush) begin
				count_q <= {CNT_W{1'b0}};
			end else if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
			wire [WIDTH-1:0] above;
			if (i == DEPTH - 1) begin : g_top
				assign above = {WIDTH{1'b0}};
			end else begin : g_mid
				assign above = entry_q[i+1];
			end
			always @(posedge i_clock or negedge i_reset_n) begin
				if (!i_reset_n) begin
					entry_q[i] <= {WIDTH{1'b0}};
				end else if (i_clock_en && !i_flush) begin
					if (pop && push && (count_q == i + 1)) begin
						entry_q[i] <= i_in_data;
					end else if (pop) begin
						entry_q[i] <= above;
					end else if (push && (count_q == i)) begin
						entry_q[i] <= i_in_data;
					end
				end
			end
		end
	endgenerate
endmodule // tbs_fifo

// ==== src/tbs_serializer.v ====
// Ten-bit serializer front end: captures parallel words on the transmit clock,
// buffers them and sends framed serial words with sync bursts and a test port.
// Assumes every pin input is asynchronous to i_clock and that i_clock runs well
// above the transmit clock and the test clock, since both are found by sampling.
`timescale 1ns/1ps
`include "tbs_serializer_map.vh"
module tbs_serializer #(
	parameter DATA_W = `TBS_DATA_W,
	parameter FIFO_DEPTH = `TBS_FIFO_DEPTH,
	parameter [31:0] IDCODE = 32'h00000001
) (
	// Clock, reset and clock enable
	input wire i_clock,
	input wire i_reset_n,
	input wire i_clock_en,
	// Parallel side pins
	input wire [DATA_W-1:0] i_data,
	input wire i_transmit_clock,
	input wire i_capture_edge_select,
	input wire i_serial_drive_enable,
	input wire i_sleep_request_n,
	input wire i_sync_request_a,
	input wire i_sync_request_b,
	// Serial pair
	output reg o_serial_p,
	output reg o_serial_n,
	output reg o_serial_p_oe,
	output reg o_serial_n_oe,
	output reg o_pll_run,
	// Test access port
	input wire i_tck,
	input wire i_tms,
	input wire i_tdi,
	input wire i_trst_n,
	output reg o_tdo,
	output reg o_tdo_oe,
	// Register port
	input wire [`TBS_ADDR_W-1:0] i_reg_addr,
	input wire [31:0] i_reg_wdata,
	input wire i_reg_write,
	input wire i_reg_read,
	output reg [31:0] o_reg_rdata
);
	localparam PIN_W = DATA_W + 10;

	// Every pin passes two flip-flops; only the second stage is read.
	wire [PIN_W-1:0] pins;
	reg [PIN_W-1:0] meta_q;
	reg [PIN_W-1:0] sync_q;
	assign pins = {i_trst_n, i_tdi, i_tms, i_tck, i_sleep_request_n, i_serial_drive_enable,
		i_capture_edge_select, i_sync_request_b, i_sync_request_a, i_transmit_clock, i_data};

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_q <= {PIN_W{1'b0}};
			sync_q <= {PIN_W{1'b0}};
		end else if (i_clock_en) begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end

	wire [DATA_W-1:0] data_s = sync_q[DATA_W-1:0];
	wire transmit_clock_s = sync_q[DATA_W];
	wire sync_req = sync_q[DATA_W+1] | sync_q[DATA_W+2]; // and
	wire edge_sel_s = sync_q[DATA_W+3];
	wire drive_en_s = sync_q[DATA_W+4];
	wire awake_s = sync_q[DATA_W+5];
	wire tck_s = sync_q[DATA_W+6];
	wire tms_s = sync_q[DATA_W+7];
	wire tdi_s = sync_q[DATA_W+8];
	wire trst_n_s = sync_q[DATA_W+9];

	// Transmit clock edge detection; data travel through the same two stages so
	// they stay aligned with the edge that strobes them.
	reg transmit_clock_d_q;
	reg tck_d_q;
	wire transmit_clock_rise = transmit_clock_s & ~transmit_clock_d_q;
	wire transmit_clock_fall = ~transmit_clock_s & transmit_clock_d_q;
	wire strobe = edge_sel_s ? transmit_clock_rise : transmit_clock_fall; // and
	wire tck_rise = tck_s & ~tck_d_q;
	wire tck_fall = ~tck_s & tck_d_q;

	// Registers and capture.
	reg ctrl_msb_first_q;
	reg overflow_q;
	reg [DATA_W-1:0] cap_q;
	reg cap_valid_q;
	reg [15:0] sync_cnt_q;
	reg [15:0] word_cnt_q;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [DATA_W-1:0] fifo_out_data;
	wire asleep = ~awake_s;
	wire clear_ovf = i_reg_write && (i_reg_addr == `TBS_OFS_STATUS) &&
		i_reg_wdata[`TBS_STAT_OVERFLOW];

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			transmit_clock_d_q <= 1'b0;
			tck_d_q <= 1'b0;
			cap_q <= {DATA_W{1'b0}};
			cap_valid_q <= 1'b0;
			overflow_q <= 1'b0;
			ctrl_msb_first_q <= `TBS_CTRL_RESET;
		end else if (i_clock_en) begin
			transmit_clock_d_q <= transmit_clock_s;
			tck_d_q <= tck_s;
			cap_valid_q <= strobe & awake_s;
			if (strobe && awake_s) begin
				cap_q <= data_s;
			end
			// A word that meets a full buffer is dropped; the set wins over a clear.
			if (cap_valid_q && !fifo_in_ready) begin
				overflow_q <= 1'b1;
			end else if (clear_ovf) begin
				overflow_q <= 1'b0;
			end
			if (i_reg_write && (i_reg_addr == `TBS_OFS_CTRL)) begin
				ctrl_msb_first_q <= i_reg_wdata[`TBS_CTRL_MSB_FIRST];
			end
		end
	end

	// Serializer: one bit per enabled clock, frames back to back.
	reg [`TBS_FRAME_BITS-1:0] shift_q;
	reg [`TBS_BIT_CNT_W-1:0] bit_cnt_q;
	reg [`TBS_SYNC_CNT_W-1:0] sync_left_q;
	reg sync_active_q;
	wire frame_end = (bit_cnt_q == `TBS_LAST_BIT);
	wire send_sync = sync_req | (sync_left_q != {`TBS_SYNC_CNT_W{1'b0}});
	wire pop = frame_end & ~send_sync & fifo_out_valid & awake_s;
	reg [DATA_W-1:0] next_word;
	reg [DATA_W-1:0] ordered;
	integer k;

	always @* begin
		next_word = send_sync ? `TBS_SYNC_SYMBOL : (fifo_out_valid ? fifo_out_data :
			{DATA_W{1'b0}});
		ordered = next_word;
		for (k = 0; k < DATA_W; k = k + 1) begin
			if (ctrl_msb_first_q) begin
				ordered[k] = next_word[DATA_W-1-k];
			end
		end
	end

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shift_q <= {`TBS_FRAME_BITS{1'b0}};
			bit_cnt_q <= {`TBS_BIT_CNT_W{1'b0}};
			sync_left_q <= {`TBS_SYNC_CNT_W{1'b0}};
			sync_active_q <= 1'b0;
			sync_cnt_q <= 16'h0000;
			word_cnt_q <= 16'h0000;
		end else if (i_clock_en) begin
			if (asleep) begin
				// The PLL is stopped: the frame restarts cleanly on wake-up.
				shift_q <= {`TBS_FRAME_BITS{1'b0}};
				bit_cnt_q <= `TBS_LAST_BIT;
				sync_left_q <= {`TBS_SYNC_CNT_W{1'b0}};
				sync_active_q <= 1'b0;
			end else if (frame_end) begin
				// Start bit first, ten data bits, then the end clock bit.
				shift_q <= {`TBS_CLK_BIT_END, ordered, `TBS_CLK_BIT_START}; // and
				bit_cnt_q <= {`TBS_BIT_CNT_W{1'b0}};
				sync_active_q <= send_sync;
				if (send_sync) begin
					sync_cnt_q <= sync_cnt_q + 16'h0001;
					// A fresh request arms the full burst; this frame is its first.
					if (sync_left_q == {`TBS_SYNC_CNT_W{1'b0}}) begin
						sync_left_q <= `TBS_SYNC_MIN - 1'b1;
					end else begin
						sync_left_q <= sync_left_q - 1'b1;
					end
				end else if (pop) begin
					word_cnt_q <= word_cnt_q + 16'h0001;
				end
			end else begin
				shift_q <= {1'b0, shift_q[`TBS_FRAME_BITS-1:1]};
				bit_cnt_q <= bit_cnt_q + 1'b1;
			end
		end
	end

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_serial_p <= 1'b0;
			o_serial_n <= 1'b0;
			o_serial_p_oe <= 1'b0;
			o_serial_n_oe <= 1'b0;
			o_pll_run <= 1'b0;
		end else if (i_clock_en) begin
			o_serial_p <= shift_q[0];
			o_serial_n <= ~shift_q[0];
			o_serial_p_oe <= drive_en_s & awake_s; // and
			o_serial_n_oe <= drive_en_s & awake_s; // and
			o_pll_run <= awake_s;
		end
	end

	tbs_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.CNT_W(3)
	) u_fifo (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_clock_en(i_clock_en),
		.i_flush(asleep),
		.i_in_valid(cap_valid_q),
		.i_in_data(cap_q),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out_data),
		.i_out_ready(pop)
	);

	// Register read port: data stand in the cycle after the strobe only.
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= 32'h00000000;
		end else if (i_clock_en) begin
			o_reg_rdata <= 32'h00000000;
			if (i_reg_read) begin
				case (i_reg_addr)
					`TBS_OFS_CTRL: o_reg_rdata <= {31'h00000000, ctrl_msb_first_q};
					`TBS_OFS_STATUS: o_reg_rdata <= {27'h0000000, ~fifo_out_valid, overflow_q,
						o_serial_p_oe, asleep, sync_active_q};
					`TBS_OFS_SYNC_CNT: o_reg_rdata <= {16'h0000, sync_cnt_q};
					`TBS_OFS_WORD_CNT: o_reg_rdata <= {16'h0000, word_cnt_q};
					default: o_reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Test access port, stepped on sampled test clock edges.
	function [3:0] tap_next;
		input [3:0] st;
		input tms;
		begin
			case (st)
				`TBS_TAP_RESET: tap_next = tms ? `TBS_TAP_RESET : `TBS_TAP_IDLE;
				`TBS_TAP_IDLE: tap_next = tms ? `TBS_TAP_SEL_DR : `TBS_TAP_IDLE;
				`TBS_TAP_SEL_DR: tap_next = tms ? `TBS_TAP_SEL_IR : `TBS_TAP_CAP_DR;
				`TBS_TAP_CAP_DR: tap_next = tms ? `TBS_TAP_EXIT1_DR : `TBS_TAP_SHIFT_DR;
				`TBS_TAP_SHIFT_DR: tap_next = tms ? `TBS_TAP_EXIT1_DR : `TBS_TAP_SHIFT_DR;
				`TBS_TAP_EXIT1_DR: tap_next = tms ? `TBS_TAP_UPD_DR : `TBS_TAP_PAUSE_DR;
				`TBS_TAP_PAUSE_DR: tap_next = tms ? `TBS_TAP_EXIT2_DR : `TBS_TAP_PAUSE_DR;
				`TBS_TAP_EXIT2_DR: tap_next = tms ? `TBS_TAP_UPD_DR : `TBS_TAP_SHIFT_DR;
				`TBS_TAP_UPD_DR: tap_next = tms ? `TBS_TAP_SEL_DR : `TBS_TAP_IDLE;
				`TBS_TAP_SEL_IR: tap_next = tms ? `TBS_TAP_RESET : `TBS_TAP_CAP_IR;
				`TBS_TAP_CAP_IR: tap_next = tms ? `TBS_TAP_EXIT1_IR : `TBS_TAP_SHIFT_IR;
				`TBS_TAP_SHIFT_IR: tap_next = tms ? `TBS_TAP_EXIT1_IR : `TBS_TAP_SHIFT_IR;
				`TBS_TAP_EXIT1_IR: tap_next = tms ? `TBS_TAP_UPD_IR : `TBS_TAP_PAUSE_IR;
				`TBS_TAP_PAUSE_IR: tap_next = tms ? `TBS_TAP_EXIT2_IR : `TBS_TAP_PAUSE_IR;
				`TBS_TAP_EXIT2_IR: tap_next = tms ? `TBS_TAP_UPD_IR : `TBS_TAP_SHIFT_IR;
				`TBS_TAP_UPD_IR: tap_next = tms ? `TBS_TAP_SEL_DR : `TBS_TAP_IDLE;
				default: tap_next = `TBS_TAP_RESET;
			endcase
		end
	endfunction

	reg [3:0] tap_q;
	reg [1:0] ir_q;
	reg [1:0] ir_sh_q;
	reg [31:0] dr_q;
	// The boundary register only samples the pins; no pin is overridden.
	wire [`TBS_BSR_LEN-1:0] bsr_cap = sync_q[`TBS_BSR_LEN-1:0];

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tap_q <= `TBS_TAP_RESET;
			ir_q <= `TBS_IR_IDCODE;
			ir_sh_q <= 2'h0;
			dr_q <= 32'h00000000;
			o_tdo <= 1'b0;
			o_tdo_oe <= 1'b0;
		end else if (i_clock_en) begin
			if (!trst_n_s) begin
				tap_q <= `TBS_TAP_RESET;
				ir_q <= `TBS_IR_IDCODE;
				o_tdo_oe <= 1'b0;
			end else if (tck_rise) begin
				tap_q <= tap_next(tap_q, tms_s);
				case (tap_q)
					`TBS_TAP_RESET: ir_q <= `TBS_IR_IDCODE;
					`TBS_TAP_CAP_IR: ir_sh_q <= `TBS_IR_CAPTURE;
					`TBS_TAP_SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[1]};
					`TBS_TAP_UPD_IR: ir_q <= ir_sh_q;
					`TBS_TAP_CAP_DR: begin
						if (ir_q == `TBS_IR_IDCODE) begin
							dr_q <= IDCODE;
						end else if (ir_q == `TBS_IR_SAMPLE) begin
							dr_q <= {16'h0000, bsr_cap};
						end else begin
							dr_q <= 32'h00000000;
						end
					end
					`TBS_TAP_SHIFT_DR: begin
						if (ir_q == `TBS_IR_IDCODE) begin
							dr_q <= {tdi_s, dr_q[31:1]};
						end else if (ir_q == `TBS_IR_SAMPLE) begin
							dr_q <= {16'h0000, tdi_s, dr_q[`TBS_BSR_LEN-1:1]};
						end else begin
							dr_q <= {31'h00000000, tdi_s};
						end
					end
					default: ir_q <= ir_q;
				endcase
			end else if (tck_fall) begin
				// The test output changes on the falling edge and drives only while shifting.
				o_tdo <= (tap_q == `TBS_TAP_SHIFT_IR) ? ir_sh_q[0] : dr_q[0];
				o_tdo_oe <= (tap_q == `TBS_TAP_SHIFT_IR) || (tap_q == `TBS_TAP_SHIFT_DR);
			end
		end
	end
endmodule // tbs_serializer

// ==== dv/tbs_serializer_assertions.sv ====
// Checker for the serializer pins: drive enable, sleep, sync bursts, test reset.
// Assumes a bind onto tbs_serializer and sees only its ports.
`timescale 1ns/1ps
module tbs_serializer_assertions (
	// Clock and reset
	input wire i_clock,
	input wire i_reset_n,
	// Control pins
	input wire i_serial_drive_enable,
	input wire i_sleep_request_n,
	input wire i_sync_request_a,
	input wire i_sync_request_b,
	input wire i_trst_n,
	// Driven pins
	input wire o_serial_p,
	input wire o_serial_n,
	input wire o_serial_p_oe,
	input wire o_serial_n_oe,
	input wire o_pll_run,
	input wire o_tdo_oe
);
	logic run;
	logic [5:0] held_q;
	logic [7:0] hold_q;
	logic [13:0] gap_q;
	logic pulse_ok_q;
	assign run = i_sleep_request_n && i_serial_drive_enable;
	// A short request still owes a whole burst, so the gap after it is timed.
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			held_q <= 6'h00;
			hold_q <= 8'h00;
			gap_q <= 14'h3fff;
			pulse_ok_q <= 1'b0;
		end else if (!run) begin
			held_q <= 6'h00;
			hold_q <= 8'hff;
			gap_q <= 14'h3fff;
			pulse_ok_q <= 1'b0;
		end else if (i_sync_request_a || i_sync_request_b) begin
			held_q <= held_q + {5'h00, held_q != 6'h3f};
			hold_q <= hold_q + {7'h00, hold_q != 8'hff};
			gap_q <= 14'h0000;
		end else begin
			held_q <= 6'h00;
			hold_q <= 8'h00;
			gap_q <= gap_q + {13'h0000, gap_q != 14'h3fff};
			if (gap_q == 14'h0000) begin
				pulse_ok_q <= hold_q >= 8'h20 && hold_q < 8'hc8;
			end
		end
	end
	default clocking dc @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	sequence s_drive_off;
		(!i_serial_drive_enable) [*5];
	endsequence
	sequence s_asleep;
		(!i_sleep_request_n) [*5];
	endsequence
	sequence s_live;
		(i_sleep_request_n && i_serial_drive_enable) [*8];
	endsequence
	drive_off_float_a: assert property (s_drive_off |-> !o_serial_p_oe && !o_serial_n_oe)
		else $error("pair driven while disabled");
	drive_on_a: assert property (s_live |-> o_serial_p_oe && o_serial_n_oe)
		else $error("pair not driven");
	pair_inverse_a: assert property (o_serial_p_oe |-> o_serial_n != o_serial_p)
		else $error("pair not inverse");
	oe_pair_a: assert property (o_serial_p_oe == o_serial_n_oe)
		else $error("pair enables differ");
	sleep_float_a: assert property (s_asleep |-> !o_pll_run && !o_serial_p_oe)
		else $error("awake while sleep requested");
	wake_pll_a: assert property (i_sleep_request_n [*5] |-> o_pll_run)
		else $error("pll stopped while awake");
	sync_repeat_a: assert property (held_q == 6'h3f |-> o_serial_p == $past(o_serial_p, 12))
		else $error("sync stream broken while held");
	sync_burst_a: assert property (pulse_ok_q && gap_q >= 14'h003c && gap_q <= 14'h2ee0
		|-> o_serial_p == $past(o_serial_p, 12))
		else $error("sync burst cut short");
	tap_reset_a: assert property ((!i_trst_n) [*5] |-> !o_tdo_oe)
		else $error("test data driven in reset");
endmodule // tbs_serializer_assertions
bind tbs_serializer tbs_serializer_assertions tbs_serializer_assertions_i (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_serial_drive_enable(i_serial_drive_enable),
	.i_sleep_request_n(i_sleep_request_n), .i_sync_request_a(i_sync_request_a),
	.i_sync_request_b(i_sync_request_b), .i_trst_n(i_trst_n), .o_serial_p(o_serial_p),
	.o_serial_n(o_serial_n), .o_serial_p_oe(o_serial_p_oe), .o_serial_n_oe(o_serial_n_oe),
	.o_pll_run(o_pll_run), .o_tdo_oe(o_tdo_oe)
);

// ==== dv/tbs_deser_model.sv ====
// Far-side receiver model: recovers framed words from the serial pair, reports lock.
// Assumes one bit per i_clock and a twelve-bit frame.
`timescale 1ns/1ps
module tbs_deser_model (
	// Clock and reset
	input wire i_clock,
	input wire i_reset_n,
	// Serial pair
	input wire i_serial_p,
	input wire i_serial_n,
	input wire i_serial_oe,
	// Recovered words
	output logic [9:0] o_word,
	output logic o_word_valid,
	output logic o_lock_n,
	output logic o_frame_err
);
	logic line;
	logic [3:0] cnt;
	logic [11:0] sh;
	logic [11:0] nxt;
	assign nxt = {line, sh[11:1]};
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			line <= 1'b0;
			cnt <= 4'h0;
			sh <= 12'h000;
			o_word <= 10'h000;
			o_word_valid <= 1'b0;
			o_lock_n <= 1'b1;
			o_frame_err <= 1'b0;
		end else begin
			// A floating pair must not look like a held level.
			line <= i_serial_oe ? i_serial_p : ~line;
			sh <= nxt;
			o_word_valid <= 1'b0;
			if (i_serial_oe && i_serial_n === i_serial_p) begin
				o_frame_err <= 1'b1;
			end
			if (o_lock_n) begin
				if (nxt == 12'h03f) begin
					o_lock_n <= 1'b0;
					cnt <= 4'h0;
				end
			end else if (cnt == 4'hb) begin
				cnt <= 4'h0;
				o_word <= nxt[10:1];
				o_word_valid <= 1'b1;
				if (nxt[0] !== 1'b1 || nxt[11] !== 1'b0) begin
					o_frame_err <= 1'b1;
				end
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule // tbs_deser_model

// ==== dv/tbs_serializer_test.sv ====
// Testbench for the serializer: registers, capture edges, stalls, sync and scan.
// Assumes the receiver model closes the lock loop onto the second sync pin.
`timescale 1ns/1ps
module tbs_serializer_test;
	localparam logic [31:0] TB_IDCODE = 32'h0000_0c35; // Arbitrary value.
	logic i_clock = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_clock_en = 1'b1;
	logic [9:0] i_data = 10'h000;
	logic i_transmit_clock = 1'b0;
	logic i_capture_edge_select = 1'b1;
	logic i_serial_drive_enable = 1'b1;
	logic i_sleep_request_n = 1'b1;
	logic i_sync_request_a = 1'b0;
	logic i_tck = 1'b0;
	logic i_tms = 1'b1;
	logic i_tdi = 1'b0;
	logic i_trst_n = 1'b0;
	logic [3:0] i_reg_addr = 4'h0;
	logic [31:0] i_reg_wdata = 32'h0;
	logic i_reg_write = 1'b0;
	logic i_reg_read = 1'b0;
	wire o_serial_p, o_serial_n, o_serial_p_oe, o_serial_n_oe, o_pll_run, o_tdo, o_tdo_oe;
	wire [31:0] o_reg_rdata;
	wire [9:0] rx_word;
	wire rx_valid, rx_lock_n, rx_err;
	int n_errors = 0;
	int tests_run = 0;
	logic [9:0] rx_q[$];
	logic [31:0] v, c0;
	logic [9:0] words [6] = '{10'h2a5, 10'h15a, 10'h3c3, 10'h0f0, 10'h301, 10'h1fe};
	always #20 i_clock = ~i_clock;
	tbs_serializer #(.IDCODE(TB_IDCODE)) tbs_serializer_i (
		.i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_en(i_clock_en), .i_data(i_data),
		.i_transmit_clock(i_transmit_clock), .i_capture_edge_select(i_capture_edge_select),
		.i_serial_drive_enable(i_serial_drive_enable), .i_sleep_request_n(i_sleep_request_n),
		.i_sync_request_a(i_sync_request_a), .i_sync_request_b(rx_lock_n),
		.o_serial_p(o_serial_p), .o_serial_n(o_serial_n), .o_serial_p_oe(o_serial_p_oe),
		.o_serial_n_oe(o_serial_n_oe), .o_pll_run(o_pll_run), .i_tck(i_tck), .i_tms(i_tms),
		.i_tdi(i_tdi), .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
		.i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata));
	tbs_deser_model tbs_deser_model_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_serial_p(o_serial_p), .i_serial_n(o_serial_n), .i_serial_oe(o_serial_p_oe),
		.o_word(rx_word), .o_word_valid(rx_valid), .o_lock_n(rx_lock_n), .o_frame_err(rx_err));
	// Idle and sync frames carry no user word, so test words avoid both values.
	always @(posedge i_clock) begin
		if (rx_valid && rx_word !== 10'h000 && rx_word !== 10'h01f) begin
			rx_q.push_back(rx_word);
		end
	end
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_write <= 1'b1;
		@(posedge i_clock);
		i_reg_write <= 1'b0;
	endtask
	// Called at a clock edge; returns at an edge so later stimulus stays on edges.
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		i_reg_addr <= a;
		i_reg_read <= 1'b1;
		@(posedge i_clock);
		i_reg_read <= 1'b0;
		#1 d = o_reg_rdata;
		@(posedge i_clock);
	endtask
	// One transmit clock period; the inactive edge meets corrupted data on purpose.
	task automatic send(input logic [9:0] d);
		i_data <= d;
		cyc(4);
		i_transmit_clock <= ~i_transmit_clock;
		cyc(3);
		i_data <= ~d;
		cyc(1);
		i_transmit_clock <= ~i_transmit_clock;
	endtask
	task automatic tick(input logic ms, output logic b);
		i_tms <= ms;
		cyc(5);
		#1 b = o_tdo;
		cyc(1);
		i_tck <= 1'b1;
		cyc(4);
		i_tck <= 1'b0;
	endtask
	task automatic tap_id(output logic [31:0] id);
		logic b;
		i_trst_n <= 1'b0;
		cyc(6);
		i_trst_n <= 1'b1;
		tick(1'b0, b);
		tick(1'b1, b);
		tick(1'b0, b);
		tick(1'b0, b);
		for (int i = 0; i < 32; i++) begin
			tick(i == 31, b);
			id[i] = b;
		end
		tick(1'b1, b);
		tick(1'b0, b);
	endtask
	// From idle: loads the instruction and returns the two captured bits.
	task automatic tap_ir(input logic [1:0] code, output logic [1:0] cap);
		logic b;
		tick(1'b1, b);
		tick(1'b1, b);
		tick(1'b0, b);
		tick(1'b0, b);
		for (int i = 0; i < 2; i++) begin
			i_tdi <= code[i];
			tick(i == 1, b);
			cap[i] = b;
		end
		tick(1'b1, b);
		tick(1'b0, b);
	endtask
	// From idle: captures the selected data register and shifts n bits out.
	task automatic tap_dr(input int n, input logic di, output logic [31:0] got);
		logic b;
		got = 32'h0;
		i_tdi <= di;
		tick(1'b1, b);
		tick(1'b0, b);
		tick(1'b0, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, b);
			got[i] = b;
		end
		tick(1'b1, b);
		tick(1'b0, b);
	endtask
	initial begin
		cyc(6);
		i_reset_n <= 1'b1;
		i_trst_n <= 1'b1;
		rd(4'h0, v);
		chk(v, 32'h0, "control reset");
		wr(4'h0, 32'h1);
		rd(4'h0, v);
		chk(v, 32'h1, "control write");
		wr(4'h0, 32'h0);
		rd(4'h2, v);
		chk(v, 32'h0, "unmapped read");
		cyc(200);
		chk(rx_lock_n, 1'b0, "far side lock");
		cyc(12600);
		rd(4'h8, c0);
		chk(c0, 32'h400, "sync burst length");
		i_sync_request_a <= 1'b1;
		cyc(40);
		foreach (words[i]) send(words[i]);
		rd(4'h4, v);
		chk(v & 32'h1f, 32'h0d, "stalled status");
		wr(4'h4, 32'h8);
		rd(4'h4, v);
		chk(v & 32'h8, 32'h0, "overflow clear");
		cyc(14000);
		i_sync_request_a <= 1'b0;
		for (int i = 0; i < 8000 && v[0] !== 1'b0; i++) rd(4'h4, v);
		chk(v & 32'h1, 32'h0, "sync ended");
		rd(4'h8, v);
		chk(v - c0 >= 32'h44c, 32'h1, "held sync");
		cyc(80);
		chk(rx_q.size(), 32'h4, "words kept");
		for (int i = 0; i < 4; i++) chk(rx_q[i], words[i], "word");
		rx_q.delete();
		wr(4'h0, 32'h1);
		i_capture_edge_select <= 1'b0;
		cyc(6);
		i_transmit_clock <= 1'b1;
		cyc(6);
		send(10'h0c5);
		cyc(16);
		send(10'h3a0);
		cyc(60);
		chk(rx_q.size(), 32'h2, "falling words");
		chk({rx_q[0], rx_q[1]}, {10'h28c, 10'h017}, "msb first");
		chk(rx_err, 1'b0, "frame bits");
		i_serial_drive_enable <= 1'b0;
		cyc(8);
		rd(4'h4, v);
		chk(v & 32'h4, 32'h0, "drive status");
		chk(o_serial_p_oe, 1'b0, "pair floats");
		i_serial_drive_enable <= 1'b1;
		i_sleep_request_n <= 1'b0;
		cyc(8);
		rd(4'h4, v);
		chk(v & 32'h2, 32'h2, "asleep status");
		chk({o_pll_run, o_serial_p_oe}, 2'b00, "sleep outputs");
		i_sleep_request_n <= 1'b1;
		tap_id(v);
		chk(v, TB_IDCODE, "scan code");
		tap_ir(2'h3, v[1:0]);
		chk(v[1:0], 32'h1, "ir capture");
		tap_dr(3, 1'b1, v);
		chk(v, 32'h6, "bypass path");
		tap_ir(2'h1, v[1:0]);
		tap_dr(16, 1'b0, v);
		chk(v, 32'hc45f, "pin sample");
		// A write while the clock enable is low must leave the control bit alone.
		i_clock_en <= 1'b0;
		wr(4'h0, 32'h0);
		i_clock_en <= 1'b1;
		rd(4'h0, v);
		chk(v, 32'h1, "frozen write");
		// A short request still owes the whole minimum burst.
		rd(4'h8, c0);
		i_sync_request_a <= 1'b1;
		cyc(100);
		i_sync_request_a <= 1'b0;
		cyc(12400);
		rd(4'h8, v);
		chk(v - c0, 32'h400, "short request burst");
		give_verdict();
	end
	initial begin
		cyc(70000);
		n_errors++;
		$display("wrong value at %0t: run did not finish", $time);
		give_verdict();
	end
endmodule // tbs_serializer_test
